/* File: qei_map.svh */
// constants of the quadrature encoder interface: register indices, bits, resets
// assumes a 32-bit apb slave whose byte address is four times the register index
//
// Contract
// - encoder count is signed 32-bit, host reads it and overwrites it freely
// - position is parameter 216, settings 217, maximum deviation 218
// - quadrature decode gives four counts per encoder line per rotation
// - each count step is scaled by settings value divided by 512
// - scaled counter follows microsteps: microsteps per rotation = prescaler * ticks
// - settings bits 2 to 4 are special functions, not part of prescaler
// - bit 2 set zeroes the counter at the next null channel event
// - bits 3 and 2 set zero the counter at every null event
// - bit 4 picks the null level that clears: zero low, one high
// - position difference above maximum deviation stops motor and flags error
// - maximum deviation of zero turns deviation supervision off
`ifndef QEI_MAP_SVH
`define QEI_MAP_SVH

// register indices, byte address is index times four
`define QEI_IDX_POS      10'h0d8
`define QEI_IDX_SET      10'h0d9
`define QEI_IDX_MAXDEV   10'h0da
`define QEI_IDX_STATUS   10'h0db

// settings word fields
`define QEI_BIT_ONCE     2
`define QEI_BIT_EACH     3
`define QEI_BIT_POL      4
`define QEI_SPECIAL_MASK 32'h0000_001c
`define QEI_FRAC_W       9

// status word fields
`define QEI_ST_DEVERR    0
`define QEI_ST_NULL      1

// reset values
`define QEI_POS_RST      32'h0000_0000
`define QEI_SET_RST      32'h0000_0200
`define QEI_MAXDEV_RST   32'h0000_0000

`endif

/* File: qei_pkg.sv */
// types of the quadrature encoder interface
// assumes qei_map.svh is on the include path
`default_nettype none
`include "qei_map.svh"

package qei_pkg;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } qei_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } qei_apb_rsp_t;

  // quadrature phase as {a, b}
  typedef enum logic [1:0] {
    QEI_PH_00 = 2'b00,
    QEI_PH_01 = 2'b01,
    QEI_PH_10 = 2'b10,
    QEI_PH_11 = 2'b11
  } qei_phase_t;

  // decoder state
  typedef struct packed {
    qei_phase_t prev;
    logic       primed;
    logic       inc;
    logic       dec;
    logic       bad;
  } qei_dec_state_t;

  // interface state, counter kept with fractional bits for the prescaler
  typedef struct packed {
    logic [32+`QEI_FRAC_W-1:0] acc;
    logic [31:0]               settings;
    logic [31:0]               maxdev;
    logic                      dev_err;
    logic                      null_act;
    qei_apb_rsp_t              rsp;
  } qei_state_t;

endpackage
`default_nettype wire

/* File: qei_quad_decode.sv */
// quadrature decoder: turns a/b phase changes into count up/down pulses
// assumes a and b already synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none

module qei_quad_decode
  import qei_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic a_in,
  input  wire logic b_in,
  output var  logic inc_out,
  output var  logic dec_out,
  output var  logic bad_out
);

  qei_dec_state_t st_q;
  qei_dec_state_t st_d;
  qei_phase_t     cur;

  // next phase when a leads b
  function automatic qei_phase_t qei_fwd(input qei_phase_t ph);
    unique case (ph)
      QEI_PH_00: qei_fwd = QEI_PH_10;
      QEI_PH_10: qei_fwd = QEI_PH_11;
      QEI_PH_11: qei_fwd = QEI_PH_01;
      QEI_PH_01: qei_fwd = QEI_PH_00;
    endcase
  endfunction

  // every phase edge is one count, four per line
  always_comb begin
    cur = qei_phase_t'({a_in, b_in});
    st_d = st_q;
    st_d.inc = 1'b0;
    st_d.dec = 1'b0;
    st_d.bad = 1'b0;
    if (st_q.primed && cur != st_q.prev) begin
      if (cur == qei_fwd(st_q.prev)) begin
        st_d.inc = 1'b1;
      end else if (st_q.prev == qei_fwd(cur)) begin
        st_d.dec = 1'b1;
      end else begin
        st_d.bad = 1'b1; // both flipped, no count
      end
    end
    st_d.prev = cur;
    st_d.primed = 1'b1;
  end

  // state register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= '{prev: QEI_PH_00, primed: 1'b0, inc: 1'b0, dec: 1'b0, bad: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign inc_out = st_q.inc;
  assign dec_out = st_q.dec;
  assign bad_out = st_q.bad;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_fwd_count: assert property (
    st_q.primed && cur == qei_fwd(st_q.prev) |=> inc_out && !dec_out)
    else $error("forward phase step gave no up count");

  a_double_flip: assert property (
    st_q.primed && (a_in != st_q.prev[1]) && (b_in != st_q.prev[0])
    |=> !inc_out && !dec_out && bad_out)
    else $error("double flip was counted");

endmodule
`default_nettype wire

/* File: qei_top.sv */
// quadrature encoder interface: scaled position counter, null clearing,
// deviation supervision and apb register slave
// assumes encoder pins and motor position are synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none

module qei_top
  import qei_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  input  wire qei_apb_req_t apb_req_in,
  output var  qei_apb_rsp_t apb_rsp_out,
  input  wire logic         enc_a_in,
  input  wire logic         enc_b_in,
  input  wire logic         enc_null_in,
  input  wire logic [31:0]  motor_pos_in,
  output var  logic         motor_stop_out,
  output var  logic         dev_err_out,
  output var  logic         quad_err_out
);

  localparam int ACC_W = 32 + `QEI_FRAC_W;

  qei_state_t       st_q;
  qei_state_t       st_d;
  logic             step_inc;
  logic             step_dec;
  logic             wr;
  logic             setup;
  logic [9:0]       idx;
  logic             aligned;
  logic             hit_pos;
  logic             hit_set;
  logic             hit_dev;
  logic             hit_st;
  logic [31:0]      prescale;
  logic [ACC_W-1:0] step_amt;
  logic             null_now;
  logic             null_hit;
  logic             zero_hit;
  logic [31:0]      pos;
  logic [32:0]      diff;
  logic [32:0]      mag;
  logic             over;

  // phase decoder
  qei_quad_decode u_dec (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .a_in     (enc_a_in),
    .b_in     (enc_b_in),
    .inc_out  (step_inc),
    .dec_out  (step_dec),
    .bad_out  (quad_err_out)
  );

  // true when the address is aligned and the index names the given register
  function automatic logic qei_hit(input logic [9:0] i, input logic [9:0] reg_idx,
                                   input logic al);
    qei_hit = al && (i == reg_idx);
  endfunction

  // apb decode, write lands at the access edge
  always_comb begin
    setup   = apb_req_in.psel && !apb_req_in.penable;
    wr      = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && st_q.rsp.pready;
    idx     = apb_req_in.paddr[11:2];
    aligned = (apb_req_in.paddr[1:0] == 2'h0);
    hit_pos = qei_hit(idx, `QEI_IDX_POS, aligned);
    hit_set = qei_hit(idx, `QEI_IDX_SET, aligned);
    hit_dev = qei_hit(idx, `QEI_IDX_MAXDEV, aligned);
    hit_st  = qei_hit(idx, `QEI_IDX_STATUS, aligned);
  end

  // prescaler, null detection and deviation measure
  always_comb begin
    prescale = st_q.settings & ~`QEI_SPECIAL_MASK;
    step_amt = {{`QEI_FRAC_W{1'b0}}, prescale};
    null_now = (enc_null_in == st_q.settings[`QEI_BIT_POL]);
    null_hit = null_now && !st_q.null_act;
    zero_hit = null_hit && st_q.settings[`QEI_BIT_ONCE];
    pos      = st_q.acc[ACC_W-1:`QEI_FRAC_W];
    diff     = {motor_pos_in[31], motor_pos_in} - {pos[31], pos};
    mag      = diff[32] ? (~diff + 33'h000000001) : diff;
    over     = (st_q.maxdev != 32'h0000_0000) && (mag > {1'b0, st_q.maxdev});
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.null_act = null_now;
    // scaled count in units of 1/512, so microsteps follow prescale * ticks
    if (step_inc) begin
      st_d.acc = st_q.acc + step_amt;
    end else if (step_dec) begin
      st_d.acc = st_q.acc - step_amt;
    end
    // null clearing, one shot unless the each bit is set
    if (zero_hit) begin
      st_d.acc = '0;
      if (!st_q.settings[`QEI_BIT_EACH]) begin
        st_d.settings[`QEI_BIT_ONCE] = 1'b0;
      end
    end
    // host writes take priority over counting and clearing
    if (wr && hit_pos) begin
      st_d.acc = {apb_req_in.pwdata, {`QEI_FRAC_W{1'b0}}};
    end
    if (wr && hit_set) begin
      st_d.settings = apb_req_in.pwdata;
      // new polarity must not read as an entry into the null level
      st_d.null_act = (enc_null_in == apb_req_in.pwdata[`QEI_BIT_POL]);
    end
    if (wr && hit_dev) begin
      st_d.maxdev = apb_req_in.pwdata;
    end
    // deviation flag: write one clears, a new trip wins over the clear
    if (wr && hit_st && apb_req_in.pwdata[`QEI_ST_DEVERR]) begin
      st_d.dev_err = 1'b0;
    end
    if (st_q.maxdev == 32'h0000_0000) begin
      st_d.dev_err = 1'b0;
    end
    if (over) begin
      st_d.dev_err = 1'b1;
    end
    // apb answer, ready in the access cycle, read data taken at setup
    st_d.rsp.pready  = setup;
    st_d.rsp.pslverr = setup && !(hit_pos || hit_set || hit_dev || hit_st);
    if (setup && !apb_req_in.pwrite) begin
      st_d.rsp.prdata = 32'h0000_0000;
      if (hit_pos) begin
        st_d.rsp.prdata = pos;
      end
      if (hit_set) begin
        st_d.rsp.prdata = st_q.settings;
      end
      if (hit_dev) begin
        st_d.rsp.prdata = st_q.maxdev;
      end
      if (hit_st) begin
        st_d.rsp.prdata[`QEI_ST_DEVERR] = st_q.dev_err;
        st_d.rsp.prdata[`QEI_ST_NULL]   = enc_null_in;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q.acc      <= {`QEI_POS_RST, {`QEI_FRAC_W{1'b0}}};
      st_q.settings <= `QEI_SET_RST;
      st_q.maxdev   <= `QEI_MAXDEV_RST;
      st_q.dev_err  <= 1'b0;
      st_q.null_act <= 1'b0;
      st_q.rsp      <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign apb_rsp_out    = st_q.rsp;
  assign motor_stop_out = st_q.dev_err;
  assign dev_err_out    = st_q.dev_err;

  // checks below share the system clock and reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // position write, read setup and a null clear that no write overrides
  sequence s_pos_write;
    wr && hit_pos;
  endsequence

  sequence s_read_setup;
    setup && !apb_req_in.pwrite;
  endsequence

  sequence s_null_clear;
    zero_hit && !(wr && (hit_pos || hit_set));
  endsequence

  a_pos_write: assert property (
    s_pos_write |=> pos == $past(apb_req_in.pwdata))
    else $error("position write not taken");

  a_set_read: assert property (
    s_read_setup ##0 hit_set |=> apb_rsp_out.pready && !apb_rsp_out.pslverr
      && apb_rsp_out.prdata == $past(st_q.settings))
    else $error("settings read wrong");

  a_unmapped_err: assert property (
    setup && !(hit_pos || hit_set || hit_dev || hit_st) |=> apb_rsp_out.pslverr
      && apb_rsp_out.pready ##1 !apb_rsp_out.pready)
    else $error("unmapped address not refused");

  a_step_scaled: assert property (
    step_inc && !zero_hit && !(wr && hit_pos)
    |=> st_q.acc == $past(st_q.acc) + {{`QEI_FRAC_W{1'b0}}, $past(prescale)})
    else $error("up step not scaled by prescaler");

  a_down_scaled: assert property (
    step_dec && !zero_hit && !(wr && hit_pos)
    |=> st_q.acc == $past(st_q.acc) - {{`QEI_FRAC_W{1'b0}}, $past(prescale)})
    else $error("down step not scaled by prescaler");

  a_special_out: assert property (
    (step_inc || step_dec) && (st_q.settings & ~`QEI_SPECIAL_MASK) == 32'h0000_0000
      && !null_hit
      && !(wr && hit_pos) |=> $stable(st_q.acc))
    else $error("special bits moved the counter");

  a_null_once: assert property (
    s_null_clear ##0 !st_q.settings[`QEI_BIT_EACH]
    |=> pos == 32'h0000_0000 && !st_q.settings[`QEI_BIT_ONCE])
    else $error("one shot null clear wrong");

  a_null_each: assert property (
    s_null_clear ##0 st_q.settings[`QEI_BIT_EACH]
    |=> pos == 32'h0000_0000 && st_q.settings[`QEI_BIT_ONCE])
    else $error("repeated null clear lost");

  a_null_level: assert property (
    enc_null_in != st_q.settings[`QEI_BIT_POL] && !step_inc && !step_dec
      && !(wr && hit_pos) |=> $stable(st_q.acc))
    else $error("counter cleared at wrong null level");

  a_dev_trip: assert property (
    over |=> motor_stop_out && dev_err_out)
    else $error("deviation did not stop the motor");

  a_dev_off: assert property (
    st_q.maxdev == 32'h0000_0000 |=> !motor_stop_out)
    else $error("stop with supervision off");

  // a host clear of the deviation flag
  sequence s_status_clear;
    wr && hit_st && apb_req_in.pwdata[`QEI_ST_DEVERR];
  endsequence

  // settings write lands whole, special bits included
  a_set_write: assert property (
    wr && hit_set
    |=> st_q.settings == $past(apb_req_in.pwdata))
    else $error("settings write not taken");

  // maximum deviation write lands whole
  a_dev_write: assert property (
    wr && hit_dev
    |=> st_q.maxdev == $past(apb_req_in.pwdata))
    else $error("maximum deviation write not taken");

  // maximum deviation reads back as written
  a_dev_read: assert property (
    s_read_setup ##0 hit_dev
    |=> apb_rsp_out.prdata == $past(st_q.maxdev))
    else $error("maximum deviation read wrong");

  // position read returns the integer part of the counter
  a_pos_read: assert property (
    s_read_setup ##0 hit_pos
    |=> apb_rsp_out.prdata == $past(pos))
    else $error("position read wrong");

  // status read carries the flag and zeros above the null bit
  a_status_read: assert property (
    s_read_setup ##0 hit_st
    |=> apb_rsp_out.prdata[`QEI_ST_DEVERR] == $past(st_q.dev_err)
      && apb_rsp_out.prdata[31:2] == 30'h0000_0000)
    else $error("status read wrong");

  // ready is a one cycle pulse, zero wait states
  a_ready_pulse: assert property (
    apb_rsp_out.pready
    |=> !apb_rsp_out.pready)
    else $error("ready stood longer than one cycle");

  // a refused write changes neither settings nor maximum deviation
  a_refused_write: assert property (
    wr && !(hit_pos || hit_set || hit_dev || hit_st) && !zero_hit
    |=> $stable(st_q.settings) && $stable(st_q.maxdev))
    else $error("refused write changed a register");

  // no step, clear or write leaves the counter alone
  a_count_hold: assert property (
    !step_inc && !step_dec && !zero_hit && !(wr && hit_pos)
    |=> $stable(st_q.acc))
    else $error("counter moved without a step");

  // a null level that persists is one event only
  a_null_edge: assert property (
    null_hit && !(wr && hit_set)
    |=> !null_hit)
    else $error("persisting null level taken twice");

  // deviation flag is sticky until cleared or supervision off
  a_dev_sticky: assert property (
    dev_err_out && st_q.maxdev != 32'h0000_0000
      && !(wr && hit_st && apb_req_in.pwdata[`QEI_ST_DEVERR])
    |=> dev_err_out)
    else $error("deviation flag lost without a clear");

  // a host clear with no deviation drops the stop
  a_dev_clear: assert property (
    s_status_clear ##0 !over
    |=> !dev_err_out && !motor_stop_out)
    else $error("deviation flag not cleared");

endmodule
`default_nettype wire

/* File: qei_enc_model.sv */
// behavioural incremental encoder with null channel, moved by the bench
// assumes step, jump and null requests are synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none

module qei_enc_model (
  input  wire logic clk_in,
  input  wire logic step_in,
  input  wire logic dir_in,
  input  wire logic jump_in,
  input  wire logic null_in,
  output var  logic a_out,
  output var  logic b_out,
  output var  logic null_out
);
  logic [1:0] idx_q = 2'h0;
  logic       nul_q = 1'b1;

  // gray walk {a,b} 00,10,11,01 forward: a leads b
  always @(posedge clk_in) begin
    if (jump_in) idx_q <= idx_q + 2'h2;  // both lines flip
    else if (step_in) idx_q <= dir_in ? idx_q + 2'h1 : idx_q - 2'h1;
    nul_q <= null_in;
  end

  // decode phase index to the two channels
  assign a_out    = idx_q[1] ^ idx_q[0];
  assign b_out    = idx_q[1];
  assign null_out = nul_q;
endmodule
`default_nettype wire

/* File: qei_top_tb.sv */
// testbench of the encoder interface: apb register tests and encoder traffic
// assumes qei_pkg and qei_map.svh compiled first
`timescale 1ns/100ps
`default_nettype none
`include "qei_map.svh"

module qei_top_tb;
  import qei_pkg::*;
  logic         clk_in = 1'b0;
  logic         reset_in = 1'b1;
  qei_apb_req_t req = '0;
  qei_apb_rsp_t rsp;
  logic         stp = 1'b0, dir = 1'b0, jmp = 1'b0, nul = 1'b1;
  logic         a, b, nl, stop, dev, qerr;
  logic [31:0]  mpos = 32'h0;
  logic [31:0]  rd;
  logic         er;
  int           err_count = 0;
  int           checked = 0;

  // free running clock
  always #5 clk_in = ~clk_in;

  qei_enc_model enc (.clk_in(clk_in), .step_in(stp), .dir_in(dir), .jump_in(jmp),
                     .null_in(nul), .a_out(a), .b_out(b), .null_out(nl));
  qei_top uut (.clk_in(clk_in), .reset_in(reset_in), .apb_req_in(req), .apb_rsp_out(rsp),
               .enc_a_in(a), .enc_b_in(b), .enc_null_in(nl), .motor_pos_in(mpos),
               .motor_stop_out(stop), .dev_err_out(dev), .quad_err_out(qerr));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk_in);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {idx, 2'b00}, pwdata: wd};
    @(posedge clk_in);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic rdchk(input string what, input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(what, rd, exp);
  endtask

  // n encoder steps, two cycles apart, then settle
  task automatic steps(input logic d, input int n);
    repeat (n) begin
      @(posedge clk_in);
      stp <= 1'b1;
      dir <= d;
      @(posedge clk_in);
      stp <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
  endtask

  // null dips low then returns high
  task automatic null_dip;
    @(posedge clk_in);
    nul <= 1'b0;
    repeat (4) @(posedge clk_in);
    nul <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    rdchk("pos rst", `QEI_IDX_POS, `QEI_POS_RST);
    rdchk("set rst", `QEI_IDX_SET, `QEI_SET_RST);
    rdchk("maxdev rst", `QEI_IDX_MAXDEV, `QEI_MAXDEV_RST);
    apb(1'b0, 10'h000, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, 10'h000, 32'hffff_ffff);
    chk("unmapped wr err", {31'h0, er}, 32'h1);
    rdchk("set kept", `QEI_IDX_SET, `QEI_SET_RST);
    apb(1'b1, `QEI_IDX_POS, 32'h8000_0000);
    rdchk("pos min", `QEI_IDX_POS, 32'h8000_0000);
    apb(1'b1, `QEI_IDX_POS, 32'h7fff_ffff);
    rdchk("pos max", `QEI_IDX_POS, 32'h7fff_ffff);
    $display("test registers done");
    apb(1'b1, `QEI_IDX_POS, 32'h0);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0200);
    steps(1'b1, 8);
    rdchk("fwd x1", `QEI_IDX_POS, 32'h8);
    steps(1'b0, 3);
    rdchk("back x1", `QEI_IDX_POS, 32'h5);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0400);
    steps(1'b1, 2);
    rdchk("fwd x2", `QEI_IDX_POS, 32'h9);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0100);
    steps(1'b1, 4);
    rdchk("fwd x half", `QEI_IDX_POS, 32'hb);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0208);
    steps(1'b1, 2);
    null_dip();
    rdchk("bit3 alone", `QEI_IDX_POS, 32'hd);
    @(posedge clk_in);
    jmp <= 1'b1;
    @(posedge clk_in);
    jmp <= 1'b0;
    er = 1'b0;
    repeat (4) begin
      @(posedge clk_in);
      er = er | (qerr === 1'b1);
    end
    chk("double flip", {31'h0, er}, 32'h1);
    rdchk("no count", `QEI_IDX_POS, 32'hd);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0018);
    steps(1'b1, 2);
    rdchk("special only", `QEI_IDX_POS, 32'hd);
    $display("test counting done");
    apb(1'b1, `QEI_IDX_SET, 32'h0000_0204);
    null_dip();
    rdchk("clear low", `QEI_IDX_POS, 32'h0);
    rdchk("once gone", `QEI_IDX_SET, 32'h0000_0200);
    steps(1'b1, 2);
    null_dip();
    rdchk("no reclear", `QEI_IDX_POS, 32'h2);
    apb(1'b1, `QEI_IDX_SET, 32'h0000_021c);
    null_dip();
    rdchk("clear high", `QEI_IDX_POS, 32'h0);
    steps(1'b1, 3);
    @(posedge clk_in);
    nul <= 1'b0;
    repeat (4) @(posedge clk_in);
    rdchk("low kept", `QEI_IDX_POS, 32'h3);
    nul <= 1'b1;
    repeat (4) @(posedge clk_in);
    rdchk("clear each", `QEI_IDX_POS, 32'h0);
    rdchk("each kept", `QEI_IDX_SET, 32'h0000_021c);
    $display("test null done");
    mpos <= 32'd1000;
    repeat (4) @(posedge clk_in);
    chk("off stop", {31'h0, stop}, 32'h0);
    apb(1'b1, `QEI_IDX_MAXDEV, 32'h5);
    mpos <= 32'd5;
    repeat (4) @(posedge clk_in);
    chk("at limit", {31'h0, stop}, 32'h0);
    mpos <= 32'd6;
    repeat (3) @(posedge clk_in);
    chk("over stop", {31'h0, stop}, 32'h1);
    chk("over flag", {31'h0, dev}, 32'h1);
    mpos <= 32'h0;
    rdchk("status", `QEI_IDX_STATUS, 32'h3);
    apb(1'b1, `QEI_IDX_STATUS, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("cleared", {31'h0, stop}, 32'h0);
    $display("test deviation done");
    report_and_stop();
  end
endmodule
`default_nettype wire
